// ==== rtl/timer_suite_pkg.sv ====
package timer_suite_pkg;

  // ==========================================================================
  // Sizes and reset values
  localparam int GP_COUNT = 3;
  localparam int ADV_CH = 4;
  localparam int ADV_PINS = 3;
  localparam int GP_CH = 2;
  localparam logic [15:0] CNT16_RESET = 16'h0000;
  localparam logic [7:0] CNT8_RESET = 8'h00;
  localparam logic [15:0] PSC_RESET = 16'h0000;
  localparam logic [6:0] GP_PSC_RESET = 7'h00;
  localparam logic [14:0] BAS_PSC_RESET = 15'h0000;
  localparam logic [7:0] DT_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // ==========================================================================
  // Modes
  typedef enum logic [2:0] {
    CNT_UP = 3'h1,
    CNT_DOWN = 3'h2,
    CNT_CENTER = 3'h4
  } cnt_mode_t;

  typedef enum logic [5:0] {
    SM_OFF = 6'h01,
    SM_RESET = 6'h02,
    SM_GATED = 6'h04,
    SM_TRIGGER = 6'h08,
    SM_EXTCLK = 6'h10,
    SM_ENCODER = 6'h20
  } slave_mode_t;

  typedef enum logic [4:0] {
    CC_OFF = 5'h01,
    CC_CAPTURE = 5'h02,
    CC_COMPARE = 5'h04,
    CC_PWM = 5'h08,
    CC_PULSE = 5'h10
  } cc_mode_t;

  // ==========================================================================
  // Configuration and status carriers
  typedef struct packed {
    logic enable;
    cnt_mode_t mode;
    logic one_pulse;
    logic [15:0] arr;
    slave_mode_t slave;
  } core_cfg_t;

  typedef struct packed {
    cc_mode_t mode;
    logic [15:0] ccr;
  } ch_cfg_t;

  typedef struct packed {
    core_cfg_t core;
    logic [15:0] psc;
    logic [7:0] dead_time;
    logic out_en;
    logic [2:0] safe_level;
    logic [2:0] safe_level_n;
    logic [6:0] irq_en;
    logic dma_en;
  } adv_cfg_t;

  typedef struct packed {
    core_cfg_t core;
    logic [2:0] psc_exp;
    logic trig_from_adv;
    logic [3:0] irq_en;
    logic dma_en;
  } gp_cfg_t;

  typedef struct packed {
    logic enable;
    logic [3:0] psc_exp;
    logic [7:0] arr;
    logic irq_en;
    logic dma_en;
  } bas_cfg_t;

  typedef struct packed {
    logic trig;
    logic brk;
    logic [3:0] cc;
    logic update;
  } adv_flags_t;

  typedef struct packed {
    logic trig;
    logic [1:0] cc;
    logic update;
  } gp_flags_t;

  // ==========================================================================
  // Shared helpers
  function automatic logic pow2_tick(input logic [14:0] c, input logic [3:0] e);
    logic [14:0] mask;
    mask = (15'h0001 << e) - 15'h0001;
    return (c & mask) == BAS_PSC_RESET;
  endfunction

  function automatic logic [7:0] flag_next(input logic [7:0] q, input logic [7:0] s, input logic [7:0] c);
    return s | (q & ~c);
  endfunction

endpackage

// ==== rtl/timer_core.sv ====
`timescale 1ns/1ps
module timer_core
  import timer_suite_pkg::*;
#(
  parameter int NCH = GP_CH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire core_cfg_t cfg_i,
  input wire ch_cfg_t [NCH-1:0] ch_cfg_i,
  input wire logic tick_i,
  input wire logic trig_i,
  input wire logic [NCH-1:0] cap_i,
  output logic [15:0] cnt_o,
  output logic [NCH-1:0] ref_o,
  output logic [NCH-1:0][15:0] cap_o,
  output logic [NCH-1:0] cc_evt_o,
  output logic update_o,
  output logic trig_evt_o
);

  logic trig_q;
  logic en_q;
  logic enc_q;
  logic armed;
  logic dir_down;
  logic [15:0] cnt_q;
  logic trig_edge;
  logic tick;
  logic down;
  logic at_end;
  logic step;
  logic go;
  logic need_arm;
  logic rst_hit;

  // ==========================================================================
  // Slave control
  assign trig_edge = trig_i & ~trig_q;
  assign need_arm = (cfg_i.slave == SM_TRIGGER) | cfg_i.one_pulse;
  assign go = cfg_i.enable & (armed | ~need_arm) & ((cfg_i.slave != SM_GATED) | trig_i);
  assign rst_hit = (cfg_i.slave == SM_RESET) & trig_edge;
  assign trig_evt_o = trig_edge;

  always_comb begin
    case (cfg_i.slave)
      SM_EXTCLK: tick = trig_edge;
      SM_ENCODER: tick = cap_i[0] & ~enc_q;
      default: tick = tick_i;
    endcase
    case (cfg_i.mode)
      CNT_DOWN: down = 1'b1;
      CNT_CENTER: down = dir_down;
      default: down = (cfg_i.slave == SM_ENCODER) ? cap_i[1] : 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_q <= 1'b0;
      en_q <= 1'b0;
      enc_q <= 1'b0;
      cnt_q <= CNT16_RESET;
    end else begin
      trig_q <= trig_i;
      en_q <= cfg_i.enable;
      enc_q <= cap_i[0];
      cnt_q <= cnt_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed <= 1'b0;
    end else if ((cfg_i.slave == SM_TRIGGER) ? trig_edge : (cfg_i.enable & ~en_q)) begin
      armed <= 1'b1;
    end else if (~cfg_i.enable | (update_o & cfg_i.one_pulse)) begin
      armed <= 1'b0;
    end
  end

  // ==========================================================================
  // Counter
  assign step = go & tick;
  assign at_end = down ? (cnt_o == CNT16_RESET) : (cnt_o >= cfg_i.arr);
  assign update_o = (step & at_end) | rst_hit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_o <= CNT16_RESET;
      dir_down <= 1'b0;
    end else if (rst_hit) begin
      cnt_o <= (cfg_i.mode == CNT_DOWN) ? cfg_i.arr : CNT16_RESET;
    end else if (step) begin
      if ((cfg_i.mode == CNT_CENTER) && at_end) begin
        dir_down <= ~dir_down;
        cnt_o <= down ? 16'h0001 : cfg_i.arr - 16'h0001;
      end else if (at_end) begin
        cnt_o <= down ? cfg_i.arr : CNT16_RESET;
      end else if (down) begin
        cnt_o <= cnt_o - 16'h0001;
      end else begin
        cnt_o <= cnt_o + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Capture/compare channels
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic cap_q;
    logic hit;
    assign hit = (cnt_o == ch_cfg_i[i].ccr) & (cnt_o != cnt_q);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cap_q <= 1'b0;
        cap_o[i] <= CNT16_RESET;
        ref_o[i] <= 1'b0;
        cc_evt_o[i] <= 1'b0;
      end else begin
        cap_q <= cap_i[i];
        cc_evt_o[i] <= 1'b0;
        case (ch_cfg_i[i].mode)
          CC_CAPTURE: begin
            if (cap_i[i] & ~cap_q) begin
              cap_o[i] <= cnt_o;
              cc_evt_o[i] <= 1'b1;
            end
          end
          CC_COMPARE: begin
            if (hit) begin
              ref_o[i] <= ~ref_o[i];
              cc_evt_o[i] <= 1'b1;
            end
          end
          CC_PWM: begin
            ref_o[i] <= cnt_o < ch_cfg_i[i].ccr;
            cc_evt_o[i] <= hit;
          end
          CC_PULSE: begin
            ref_o[i] <= armed & (cnt_o >= ch_cfg_i[i].ccr);
            cc_evt_o[i] <= hit;
          end
          default: begin
            ref_o[i] <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// ==== rtl/timer_suite.sv ====
`timescale 1ns/1ps
module timer_suite
  import timer_suite_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire adv_cfg_t adv_cfg_i,
  input wire ch_cfg_t [ADV_CH-1:0] adv_ch_cfg_i,
  input wire logic [ADV_PINS-1:0] adv_cap_i,
  input wire logic adv_trig_i,
  input wire logic break_i,
  input wire adv_flags_t adv_clear_i,
  output logic [ADV_PINS-1:0] adv_oc_o,
  output logic [ADV_PINS-1:0] adv_ocn_o,
  output logic [15:0] adv_cnt_o,
  output logic [ADV_CH-1:0][15:0] adv_cap_o,
  output adv_flags_t adv_flags_o,
  output logic adv_irq_o,
  output logic adv_dma_o,
  input wire gp_cfg_t [GP_COUNT-1:0] gp_cfg_i,
  input wire ch_cfg_t [GP_COUNT-1:0][GP_CH-1:0] gp_ch_cfg_i,
  input wire logic [GP_COUNT-1:0][GP_CH-1:0] gp_cap_i,
  input wire logic [GP_COUNT-1:0] gp_trig_i,
  input wire gp_flags_t [GP_COUNT-1:0] gp_clear_i,
  output logic [GP_COUNT-1:0][GP_CH-1:0] gp_pwm_o,
  output logic [GP_COUNT-1:0][15:0] gp_cnt_o,
  output logic [GP_COUNT-1:0][GP_CH-1:0][15:0] gp_cap_o,
  output gp_flags_t [GP_COUNT-1:0] gp_flags_o,
  output logic [GP_COUNT-1:0] gp_irq_o,
  output logic [GP_COUNT-1:0] gp_dma_o,
  input wire bas_cfg_t bas_cfg_i,
  input wire logic bas_clear_i,
  output logic [7:0] bas_cnt_o,
  output logic bas_flag_o,
  output logic bas_irq_o,
  output logic bas_dma_o,
  output logic dac_trig_o
);

  // ==========================================================================
  // Advanced control timer
  logic [15:0] adv_psc_cnt;
  logic adv_tick;
  logic adv_upd;
  logic adv_trig_evt;
  logic [ADV_CH-1:0] adv_ref;
  logic [ADV_CH-1:0] adv_cc_evt;
  logic [ADV_CH-1:0] adv_cap_all;
  logic [6:0] adv_flags;
  logic [7:0] adv_flag_nx;

  assign adv_tick = adv_cfg_i.core.enable & (adv_psc_cnt >= adv_cfg_i.psc);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_psc_cnt <= PSC_RESET;
    end else if (~adv_cfg_i.core.enable | adv_tick) begin
      adv_psc_cnt <= PSC_RESET;
    end else begin
      adv_psc_cnt <= adv_psc_cnt + 16'h0001;
    end
  end

  assign adv_cap_all = {adv_trig_i, adv_cap_i};

  timer_core #(
    .NCH(ADV_CH)
  ) u_adv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg_i(adv_cfg_i.core),
    .ch_cfg_i(adv_ch_cfg_i),
    .tick_i(adv_tick),
    .trig_i(adv_trig_i),
    .cap_i(adv_cap_all),
    .cnt_o(adv_cnt_o),
    .ref_o(adv_ref),
    .cap_o(adv_cap_o),
    .cc_evt_o(adv_cc_evt),
    .update_o(adv_upd),
    .trig_evt_o(adv_trig_evt)
  );

  // ==========================================================================
  // Dead time and break
  for (genvar p = 0; p < ADV_PINS; p++) begin : g_dt
    logic ref_q;
    logic oc;
    logic ocn;
    logic [7:0] dt_cnt;
    logic [7:0] next_dt;
    always_comb begin
      if (adv_ref[p] != ref_q) begin
        next_dt = adv_cfg_i.dead_time;
      end else if (dt_cnt != DT_RESET) begin
        next_dt = dt_cnt - 8'h01;
      end else begin
        next_dt = DT_RESET;
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ref_q <= 1'b0;
        dt_cnt <= DT_RESET;
        oc <= 1'b0;
        ocn <= 1'b0;
      end else begin
        ref_q <= adv_ref[p];
        dt_cnt <= next_dt;
        if (break_i | ~adv_cfg_i.out_en) begin
          oc <= adv_cfg_i.safe_level[p];
          ocn <= adv_cfg_i.safe_level_n[p];
        end else begin
          oc <= adv_ref[p] & (next_dt == DT_RESET);
          ocn <= ~adv_ref[p] & (next_dt == DT_RESET);
        end
      end
    end
    assign adv_oc_o[p] = oc;
    assign adv_ocn_o[p] = ocn;
  end

  // ==========================================================================
  // Advanced flags, interrupt and DMA
  assign adv_flag_nx = flag_next({1'b0, adv_flags}, {1'b0, adv_trig_evt, break_i, adv_cc_evt, adv_upd},
    {1'b0, adv_clear_i});

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_flags <= FLAG_RESET[6:0];
      adv_dma_o <= 1'b0;
    end else begin
      adv_flags <= adv_flag_nx[6:0];
      adv_dma_o <= adv_cfg_i.dma_en & adv_upd;
    end
  end

  assign adv_flags_o = adv_flags_t'(adv_flags);
  assign adv_irq_o = |(adv_flags & adv_cfg_i.irq_en);

  // ==========================================================================
  // General-purpose timers
  for (genvar g = 0; g < GP_COUNT; g++) begin : g_gp
    logic [6:0] pcnt;
    logic tick;
    logic trig;
    logic upd;
    logic tev;
    logic [GP_CH-1:0] ccev;
    logic [3:0] flags;
    logic [7:0] flag_nx;

    assign tick = gp_cfg_i[g].core.enable & pow2_tick({8'h00, pcnt}, {1'b0, gp_cfg_i[g].psc_exp});
    assign trig = gp_cfg_i[g].trig_from_adv ? adv_upd : gp_trig_i[g];

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pcnt <= GP_PSC_RESET;
      end else if (~gp_cfg_i[g].core.enable) begin
        pcnt <= GP_PSC_RESET;
      end else begin
        pcnt <= pcnt + 7'h01;
      end
    end

    timer_core #(
      .NCH(GP_CH)
    ) u_gp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg_i(gp_cfg_i[g].core),
      .ch_cfg_i(gp_ch_cfg_i[g]),
      .tick_i(tick),
      .trig_i(trig),
      .cap_i(gp_cap_i[g]),
      .cnt_o(gp_cnt_o[g]),
      .ref_o(gp_pwm_o[g]),
      .cap_o(gp_cap_o[g]),
      .cc_evt_o(ccev),
      .update_o(upd),
      .trig_evt_o(tev)
    );

    assign flag_nx = flag_next({4'h0, flags}, {4'h0, tev, ccev, upd}, {4'h0, gp_clear_i[g]});

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        flags <= FLAG_RESET[3:0];
        gp_dma_o[g] <= 1'b0;
      end else begin
        flags <= flag_nx[3:0];
        gp_dma_o[g] <= gp_cfg_i[g].dma_en & upd;
      end
    end

    assign gp_flags_o[g] = gp_flags_t'(flags);
    assign gp_irq_o[g] = |(flags & gp_cfg_i[g].irq_en);
  end

  // ==========================================================================
  // Basic timebase timer
  logic [14:0] bas_psc_cnt;
  logic bas_tick;
  logic bas_ovf;
  logic [7:0] bas_flag_nx;

  assign bas_tick = bas_cfg_i.enable & pow2_tick(bas_psc_cnt, bas_cfg_i.psc_exp);
  assign bas_ovf = bas_tick & (bas_cnt_o >= bas_cfg_i.arr);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bas_psc_cnt <= BAS_PSC_RESET;
    end else if (~bas_cfg_i.enable) begin
      bas_psc_cnt <= BAS_PSC_RESET;
    end else begin
      bas_psc_cnt <= bas_psc_cnt + 15'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bas_cnt_o <= CNT8_RESET;
    end else if (bas_ovf) begin
      bas_cnt_o <= CNT8_RESET;
    end else if (bas_tick) begin
      bas_cnt_o <= bas_cnt_o + 8'h01;
    end
  end

  assign bas_flag_nx = flag_next({7'h00, bas_flag_o}, {7'h00, bas_ovf}, {7'h00, bas_clear_i});

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bas_flag_o <= 1'b0;
      bas_dma_o <= 1'b0;
      dac_trig_o <= 1'b0;
    end else begin
      bas_flag_o <= bas_flag_nx[0];
      bas_dma_o <= bas_cfg_i.dma_en & bas_ovf;
      dac_trig_o <= bas_ovf;
    end
  end

  assign bas_irq_o = bas_flag_o & bas_cfg_i.irq_en;

endmodule

// ==== test/timer_suite_assertions.sv ====
`timescale 1ns/1ps
module timer_suite_assertions
  import timer_suite_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire adv_cfg_t adv_cfg_i,
  input wire logic break_i,
  input wire logic [ADV_PINS-1:0] adv_oc_o,
  input wire logic [ADV_PINS-1:0] adv_ocn_o,
  input wire adv_flags_t adv_flags_o,
  input wire logic adv_irq_o,
  input wire logic adv_dma_o,
  input wire gp_flags_t [GP_COUNT-1:0] gp_flags_o,
  input wire logic [GP_COUNT-1:0] gp_dma_o,
  input wire bas_cfg_t bas_cfg_i,
  input wire logic [7:0] bas_cnt_o,
  input wire logic bas_flag_o,
  input wire logic bas_irq_o,
  input wire logic dac_trig_o
);
  // ==========================================================================
  // Timer checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bas_wrap_zero_a: assert property (dac_trig_o |-> bas_cnt_o == 8'h00 && bas_flag_o)
    else $error("basic trigger without wrap");
  bas_pulse_a: assert property (dac_trig_o && bas_cfg_i.arr != 8'h00 |=> !dac_trig_o)
    else $error("basic trigger too long");
  bas_irq_a: assert property (bas_irq_o == (bas_flag_o && bas_cfg_i.irq_en))
    else $error("basic irq wrong");
  bas_hold_a: assert property (!$past(bas_cfg_i.enable) && !$past(rst_i) |-> $stable(bas_cnt_o))
    else $error("basic counts while off");
  brk_safe_a: assert property (break_i |=> adv_oc_o == $past(adv_cfg_i.safe_level)
    && adv_ocn_o == $past(adv_cfg_i.safe_level_n))
    else $error("break not safe");
  brk_flag_a: assert property (break_i |=> adv_flags_o.brk)
    else $error("break flag missing");
  adv_irq_a: assert property (adv_irq_o == |(adv_flags_o & adv_cfg_i.irq_en))
    else $error("advanced irq wrong");
  dead_gap_a: assert property ((adv_cfg_i.safe_level & adv_cfg_i.safe_level_n) == 3'h0
    |-> (adv_oc_o & adv_ocn_o) == 3'h0)
    else $error("pair both active");
  adv_dma_a: assert property (adv_dma_o |-> adv_flags_o.update)
    else $error("advanced dma without update");
  gp_dma_a: assert property (gp_dma_o[0] |-> gp_flags_o[0].update)
    else $error("general dma without update");

  bas_wrap_c: cover property (dac_trig_o);
  brk_c: cover property (break_i ##1 adv_flags_o.brk);
  gp_dma_c: cover property (gp_dma_o[0]);
endmodule

// ==== test/pin_model.sv ====
`timescale 1ns/1ps
module pin_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  input wire logic [7:0] len_i,
  output logic pin_o
);
  // ==========================================================================
  // Pulse train on an external pin, idle low
  initial pin_o = 1'h0;
  always begin
    @(posedge clk_i);
    if (go_i) begin
      repeat (n_i) begin
        pin_o <= 1'h1;
        repeat (len_i) @(posedge clk_i);
        pin_o <= 1'h0;
        repeat (len_i) @(posedge clk_i);
      end
    end
  end
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import timer_suite_pkg::*;
;
  logic clk_i, rst_i, adv_trig_i, break_i, bas_clear_i, cap_line, ext_line;
  adv_cfg_t adv_cfg_i;
  ch_cfg_t [ADV_CH-1:0] adv_ch_cfg_i;
  logic [ADV_PINS-1:0] adv_cap_i, adv_oc_o, adv_ocn_o;
  adv_flags_t adv_clear_i, adv_flags_o;
  logic [15:0] adv_cnt_o;
  logic [ADV_CH-1:0][15:0] adv_cap_o;
  logic adv_irq_o, adv_dma_o, bas_flag_o, bas_irq_o, bas_dma_o, dac_trig_o;
  gp_cfg_t [GP_COUNT-1:0] gp_cfg_i;
  ch_cfg_t [GP_COUNT-1:0][GP_CH-1:0] gp_ch_cfg_i;
  logic [GP_COUNT-1:0][GP_CH-1:0] gp_cap_i, gp_pwm_o;
  logic [GP_COUNT-1:0] gp_trig_i, gp_irq_o, gp_dma_o;
  gp_flags_t [GP_COUNT-1:0] gp_clear_i, gp_flags_o;
  logic [GP_COUNT-1:0][15:0] gp_cnt_o;
  logic [GP_COUNT-1:0][GP_CH-1:0][15:0] gp_cap_o;
  bas_cfg_t bas_cfg_i;
  logic [7:0] bas_cnt_o, n_r, len_r;
  logic [3:0] go, ev;
  int fail_count = 0;
  int n_tests = 0;
  cnt_mode_t modes [3] = '{CNT_UP, CNT_DOWN, CNT_CENTER};
  int per [3] = '{15, 15, 12};

  timer_suite dut (.*);
  pin_model brk_pin (.clk_i, .go_i(go[0]), .n_i(n_r), .len_i(len_r), .pin_o(break_i));
  pin_model trg_pin (.clk_i, .go_i(go[1]), .n_i(n_r), .len_i(len_r), .pin_o(adv_trig_i));
  pin_model cap_pin (.clk_i, .go_i(go[2]), .n_i(n_r), .len_i(len_r), .pin_o(cap_line));
  pin_model ext_pin (.clk_i, .go_i(go[3]), .n_i(n_r), .len_i(len_r), .pin_o(ext_line));
  assign gp_cap_i = {5'h00, cap_line};
  assign gp_trig_i = {1'h0, ext_line, 1'h0};
  assign ev = {gp_dma_o[0], adv_flags_o.brk, adv_dma_o, dac_trig_o};

  always #5 clk_i = ~clk_i;

  // ==========================================================================
  // Helpers
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wait_ev(input int k, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (ev[k] !== 1'h1 && n < 4000);
    if (n >= 4000) begin
      fail_count++;
      $display("mismatch event %0d expected 1 seen 0", k);
      stop_test();
    end
  endtask

  task fire(input int k, input logic [7:0] n, input logic [7:0] len);
    @(posedge clk_i);
    go[k] <= 1'h1;
    n_r <= n;
    len_r <= len;
    @(posedge clk_i);
    go[k] <= 1'h0;
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    int n;
    int dead;
    int act;
    clk_i = 1'h0;
    rst_i = 1'h1;
    {adv_cfg_i, adv_cap_i, adv_clear_i, gp_cfg_i, gp_clear_i, bas_cfg_i, bas_clear_i} = '0;
    go = '0;
    n_r = 8'h01;
    len_r = 8'h01;
    for (int i = 0; i < ADV_CH; i++) adv_ch_cfg_i[i] = '{CC_PWM, 16'h0005};
    adv_ch_cfg_i[3] = '{CC_CAPTURE, 16'h0000};
    for (int i = 0; i < GP_COUNT; i++) gp_ch_cfg_i[i] = '{2{'{CC_PWM, 16'h0002}}};
    gp_ch_cfg_i[0][0] = '{CC_CAPTURE, 16'h0000};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    gp_cfg_i[1] <= '{'{1'h1, CNT_UP, 1'h0, 16'h00ff, SM_EXTCLK}, 3'h0, 1'h0, 4'h0, 1'h0};
    fire(3, 8'h05, 8'h02);
    repeat (24) @(posedge clk_i);
    #1;
    check("gp ext count", gp_cnt_o[1], 5);
    check("gp pwm levels", gp_pwm_o[2:1], 4'hc);
    @(posedge clk_i);
    bas_cfg_i <= '{1'h1, 4'h1, 8'h03, 1'h1, 1'h1};
    gp_cfg_i[2] <= '{'{1'h1, CNT_UP, 1'h0, 16'h00ff, SM_EXTCLK}, 3'h0, 1'h1, 4'h0, 1'h0};
    wait_ev(0, n);
    check("bas wrap", {bas_cnt_o, bas_flag_o, bas_irq_o, bas_dma_o}, 11'h007);
    wait_ev(0, n);
    check("bas period", n, 8);
    @(posedge clk_i);
    bas_clear_i <= 1'h1;
    @(posedge clk_i);
    bas_clear_i <= 1'h0;
    #1;
    check("bas clear", {bas_flag_o, bas_irq_o}, 0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      adv_cfg_i <= '{'{1'h1, modes[i], 1'h0, 16'h0004, SM_OFF}, 16'h0002, 8'h03, 1'h1, 3'h5, 3'h2, 7'h01, 1'h1};
      wait_ev(1, n);
      wait_ev(1, n);
      check("adv period", n, per[i]);
      check("adv update irq", adv_flags_o.update & adv_irq_o, 1);
      if (i < 2)
        check("adv reload", adv_cnt_o, 4 * i);
    end
    check("gp chained count", gp_cnt_o[2], 6);
    @(posedge clk_i);
    adv_cfg_i <= '{'{1'h1, CNT_UP, 1'h0, 16'h0009, SM_OFF}, 16'h0000, 8'h03, 1'h1, 3'h5, 3'h2, 7'h01, 1'h1};
    wait_ev(1, n);
    wait_ev(1, n);
    dead = 0;
    act = 0;
    repeat (40) begin
      @(posedge clk_i);
      #1;
      dead += $countones(~(adv_oc_o | adv_ocn_o));
      act += $countones(adv_oc_o);
    end
    check("dead cycles", dead, 72);
    check("active cycles", act, 24);
    fire(0, 8'h01, 8'h03);
    wait_ev(2, n);
    check("safe levels", {adv_oc_o, adv_ocn_o}, 6'h2a);
    repeat (6) @(posedge clk_i);
    adv_clear_i <= '1;
    @(posedge clk_i);
    adv_clear_i <= '0;
    #1;
    check("brk cleared", adv_flags_o.brk, 0);
    @(posedge clk_i);
    adv_cfg_i.core.mode <= CNT_DOWN;
    adv_cfg_i.psc <= 16'h00ff;
    wait_ev(1, n);
    fire(1, 8'h01, 8'h02);
    repeat (4) @(posedge clk_i);
    #1;
    check("internal capture", adv_cap_o[3], 16'h0009);
    check("internal cc flag", adv_flags_o.cc[3], 1);
    check("pin capture idle", adv_cap_o[0], 16'h0000);
    for (int e = 0; e < 8; e++) begin
      @(posedge clk_i);
      gp_cfg_i[0] <= '{'{1'h1, CNT_DOWN, 1'h0, 16'h0003, SM_OFF}, e[2:0], 1'h0, 4'h1, 1'h1};
      wait_ev(3, n);
      wait_ev(3, n);
      check("gp period", n, 4 << e);
      check("gp reload", gp_cnt_o[0], 16'h0003);
    end
    fire(2, 8'h01, 8'h02);
    repeat (4) @(posedge clk_i);
    #1;
    check("gp capture", gp_cap_o[0][0], 16'h0003);
    check("gp cc flag irq", {gp_flags_o[0].cc[0], gp_irq_o[0]}, 2'h3);
    stop_test();
  end
endmodule

bind timer_suite timer_suite_assertions chk (.*);
